// >>> hdl/umx_alu.sv
// Execute stage for the unsigned register-immediate max and two-register min.
//
// Operation
// - Immediate form widens its 10-bit immediate by copying bit 9 upward.
// - Immediate max compares unsigned and writes the larger value.
// - Neither instruction alters the overflow flag.
// - Both instructions may branch on a condition of their result.
// - Update-memory field also writes the result to fast memory.
// - Opcode 111001 in bits 31:26 selects the two-register min.
// - Two-register min compares both sources as unsigned.
// - Two-register min writes the smaller source value.
// - Branch condition uses the compare-select condition set.
// - Min honours modulo and always-execute; immediate max carries neither.
// - Opcode 111100 selects immediate max, immediate in bits 9:0.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
module umx_alu (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic rd_we_out,
    output logic [5:0] rd_idx_out,
    output logic [31:0] rd_data_out,
    output logic branch_out,
    output logic mem_we_out,
    output logic [31:0] mem_data_out,
    output logic [2:0] modsel_out,
    output logic ae_out,
    output logic ovf_out
);
    umx_pkg::umx_state_type st;
    umx_pkg::umx_state_type next_st;

    logic [5:0] opc;
    logic is_min;
    logic is_max;
    logic [31:0] imm_ext;
    logic [31:0] sel_b;
    logic [31:0] pick;
    logic [2:0] abc;
    logic cond;
    logic mapped;
    logic setup;
    logic access;

    // Instruction decode and operand widening.
    assign opc = st.instr[umx_pkg::OPC_HI:umx_pkg::OPC_LO];
    assign is_min = (opc == umx_pkg::OPC_MIN_REG);
    assign is_max = (opc == umx_pkg::OPC_MAX_IMM);
    assign imm_ext = {{22{st.instr[umx_pkg::IMM_HI]}},
                      st.instr[umx_pkg::IMM_HI:0]};
    assign sel_b = is_max ? imm_ext : st.opb;
    assign abc = st.instr[umx_pkg::ABC_HI:umx_pkg::ABC_LO];

    // Selection; on a tie the first operand is taken, which equals the
    // second, so no extra comparator is spent on equality.
    always_comb begin
        if (is_max) begin
            pick = (st.opa >= sel_b) ? st.opa : sel_b;
        end else begin
            pick = (st.opa <= sel_b) ? st.opa : sel_b;
        end
    end

    // Compare-select condition set, shared by both instructions.
    always_comb begin
        unique case (abc)
            umx_pkg::CC_NEVER: cond = 1'b0;
            umx_pkg::CC_ALWAYS: cond = 1'b1;
            umx_pkg::CC_ZERO: cond = (pick == umx_pkg::RST_WORD);
            umx_pkg::CC_NONZERO: cond = (pick != umx_pkg::RST_WORD);
            umx_pkg::CC_FIRST: cond = (pick == st.opa);
            umx_pkg::CC_SECOND: cond = (pick == sel_b);
            umx_pkg::CC_EQUAL: cond = (st.opa == sel_b);
            umx_pkg::CC_DIFFER: cond = (st.opa != sel_b);
        endcase
    end

    // APB phase decode; the slave inserts one wait-free access cycle.
    assign setup = psel_in && !penable_in && !st.pready;
    assign access = psel_in && penable_in && st.pready;
    // Register map: INSTR at 0x00 starts an execute step when written;
    // OPA and OPB hold the source values, FLAGS bit 0 the overflow flag;
    // RESULT and STATUS are read-only and ignore writes without an error.
    // Anything else answers with pslverr and reads as zero, so a stray
    // pointer in software shows up at once instead of aliasing a register.
    assign mapped = (paddr_in == umx_pkg::OFF_INSTR) ||
                    (paddr_in == umx_pkg::OFF_OPA) ||
                    (paddr_in == umx_pkg::OFF_OPB) ||
                    (paddr_in == umx_pkg::OFF_FLAGS) ||
                    (paddr_in == umx_pkg::OFF_RESULT) ||
                    (paddr_in == umx_pkg::OFF_STATUS);

    // Next-state logic: bus slave, then the execute step.
    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.go = 1'b0;
        next_st.rd_we = 1'b0;
        next_st.mem_we = 1'b0;
        next_st.branch_pulse = 1'b0;
        if (setup) begin
            next_st.pready = 1'b1;
            next_st.pslverr = !mapped;
            unique case (paddr_in)
                umx_pkg::OFF_INSTR: next_st.prdata = st.instr;
                umx_pkg::OFF_OPA: next_st.prdata = st.opa;
                umx_pkg::OFF_OPB: next_st.prdata = st.opb;
                umx_pkg::OFF_FLAGS: next_st.prdata = {31'h0000_0000, st.ovf};
                umx_pkg::OFF_RESULT: next_st.prdata = st.result;
                umx_pkg::OFF_STATUS: begin
                    next_st.prdata = umx_pkg::RST_WORD;
                    next_st.prdata[umx_pkg::ST_DONE] = st.done;
                    next_st.prdata[umx_pkg::ST_ILLEGAL] = st.illegal;
                    next_st.prdata[umx_pkg::ST_BRANCH] = st.branch;
                    next_st.prdata[umx_pkg::ST_MEM] = st.mem_flag;
                    next_st.prdata[umx_pkg::ST_MOD_LO +: 3] = st.modsel;
                    next_st.prdata[umx_pkg::ST_AE] = st.ae;
                    next_st.prdata[umx_pkg::ST_RD_LO +: 6] = st.rd_idx;
                end
                default: next_st.prdata = umx_pkg::RST_WORD;
            endcase
        end
        // Writes take effect only at the completing access edge.
        if (access && pwrite_in) begin
            if (paddr_in == umx_pkg::OFF_INSTR) begin
                next_st.instr = pwdata_in;
                next_st.go = 1'b1;
                next_st.done = 1'b0;
            end
            if (paddr_in == umx_pkg::OFF_OPA) begin
                next_st.opa = pwdata_in;
            end
            if (paddr_in == umx_pkg::OFF_OPB) begin
                next_st.opb = pwdata_in;
            end
            if (paddr_in == umx_pkg::OFF_FLAGS) begin
                next_st.ovf = pwdata_in[0];
            end
        end
        // Execute one cycle after the instruction word lands.
        // The overflow flag is deliberately untouched here.
        if (st.go) begin
            next_st.done = 1'b1;
            next_st.illegal = !(is_min || is_max);
            next_st.rd_idx = st.instr[umx_pkg::RD_HI:umx_pkg::RD_LO];
            if (is_min || is_max) begin
                next_st.result = pick;
                next_st.rd_we = 1'b1;
                // The pulse pairs with rd_we; the level stays for STATUS.
                next_st.branch = cond;
                next_st.branch_pulse = cond;
                next_st.mem_we = st.instr[umx_pkg::UM_BIT];
                next_st.mem_flag = st.instr[umx_pkg::UM_BIT];
                // Only the register form carries the qualifiers.
                next_st.modsel = is_min ?
                    st.instr[umx_pkg::MOD_HI:umx_pkg::MOD_LO] : 3'h0;
                next_st.ae = is_min && st.instr[umx_pkg::AE_BIT];
            end else begin
                next_st.branch = 1'b0;
                next_st.mem_flag = 1'b0;
                next_st.modsel = 3'h0;
                next_st.ae = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Every output is a flip-flop of the state.
    assign prdata_out = st.prdata;
    assign pready_out = st.pready;
    assign pslverr_out = st.pslverr;
    assign rd_we_out = st.rd_we;
    assign rd_idx_out = st.rd_idx;
    assign rd_data_out = st.result;
    assign branch_out = st.branch_pulse;
    assign mem_we_out = st.mem_we;
    assign mem_data_out = st.result;
    assign modsel_out = st.modsel;
    assign ae_out = st.ae;
    assign ovf_out = st.ovf;

    // A negative-looking immediate must force the top bits of the max.
    AST_IMM_EXT: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_max && st.instr[umx_pkg::IMM_HI]
        |=> (&st.result[31:10])) else $error("immediate not widened");

    AST_MAX_SEL: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_max |=> st.rd_we && st.result >= $past(st.opa) &&
        st.result >= $past(imm_ext) &&
        (st.result == $past(st.opa) || st.result == $past(imm_ext)))
        else $error("max select wrong");

    // A FLAGS write from software in the same cycle may still move it.
    AST_OVF_KEEP: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && !(access && pwrite_in && paddr_in == umx_pkg::OFF_FLAGS)
        |=> $stable(st.ovf))
        else $error("overflow changed by execute");

    AST_BR_ALWAYS: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        st.go && (is_min || is_max) && abc == umx_pkg::CC_ALWAYS
        |=> branch_out) else $error("branch not taken");

    AST_BR_EQUAL: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_min && abc == umx_pkg::CC_EQUAL
        |=> branch_out == ($past(st.opa) == $past(st.opb)))
        else $error("compare-select condition wrong");

    AST_MEM_UPD: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && (is_min || is_max)
        |=> mem_we_out == $past(st.instr[umx_pkg::UM_BIT]) &&
        mem_data_out == rd_data_out)
        else $error("memory update wrong");

    AST_DECODE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && !is_min && !is_max |=> !rd_we_out && !mem_we_out &&
        st.illegal) else $error("unknown opcode executed");

    AST_MIN_SEL: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_min |=> st.result <= $past(st.opa) &&
        st.result <= $past(st.opb) &&
        (st.result == $past(st.opa) || st.result == $past(st.opb)))
        else $error("min select wrong");

    AST_QUAL: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_max |=> modsel_out == 3'h0 && !ae_out)
        else $error("qualifier on immediate form");

    AST_TIE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_min && st.opa == st.opb
        |=> rd_data_out == $past(st.opa))
        else $error("tie value wrong");

    AST_APB_RDY: assert property (@(posedge clock_in) disable iff (!resetn_in)
        setup |=> pready_out ##1 !pready_out)
        else $error("pready not one access cycle");

    // The destination write is one pulse per executed instruction.
    AST_WE_PULSE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        rd_we_out |=> !rd_we_out)
        else $error("destination write held too long");

    // No destination write appears without an execute step before it.
    AST_WE_CAUSE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        rd_we_out |-> $past(st.go))
        else $error("destination write without instruction");

    // A recognised opcode always produces its destination write.
    AST_WE_GO: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && (is_min || is_max) |=> rd_we_out)
        else $error("destination write missing");

    // The destination index is taken from the instruction word.
    AST_RD_IDX: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go |=> rd_idx_out == $past(st.instr[umx_pkg::RD_HI:umx_pkg::RD_LO]))
        else $error("destination index wrong");

    // The fast-memory and branch strobes only ride on a destination write.
    AST_MEM_WITH: assert property (@(posedge clock_in) disable iff (!resetn_in)
        mem_we_out |-> rd_we_out)
        else $error("memory update without result");

    AST_BR_WITH: assert property (@(posedge clock_in) disable iff (!resetn_in)
        branch_out |-> rd_we_out)
        else $error("branch without result");

    // The never, zero, first, differ and second condition codes; the nonzero code is left unchecked.
    AST_BR_NEVER: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && abc == umx_pkg::CC_NEVER |=> !branch_out)
        else $error("never condition branched");

    AST_BR_ZERO: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && (is_min || is_max) && abc == umx_pkg::CC_ZERO
        |=> branch_out == (rd_data_out == 32'h0000_0000))
        else $error("zero condition wrong");

    AST_BR_FIRST: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && (is_min || is_max) && abc == umx_pkg::CC_FIRST
        |=> branch_out == (rd_data_out == $past(st.opa)))
        else $error("first-operand condition wrong");

    AST_BR_DIFF: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_min && abc == umx_pkg::CC_DIFFER
        |=> branch_out == ($past(st.opa) != $past(st.opb)))
        else $error("differ condition wrong");

    AST_BR_IMM: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_max && abc == umx_pkg::CC_SECOND
        |=> branch_out == (rd_data_out == $past(imm_ext)))
        else $error("second-operand condition wrong");

    // The register form passes its qualifiers on unchanged.
    AST_MIN_QUAL: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_min
        |=> modsel_out == $past(st.instr[umx_pkg::MOD_HI:umx_pkg::MOD_LO]) &&
        ae_out == $past(st.instr[umx_pkg::AE_BIT]))
        else $error("qualifier lost on register form");

    // A tie with the widened immediate still writes the common value.
    AST_MAX_TIE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_max && st.opa == imm_ext
        |=> rd_data_out == $past(st.opa))
        else $error("immediate tie value wrong");

    // An unknown opcode must not steer program flow.
    AST_BAD_NOBR: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && !is_min && !is_max |=> !branch_out)
        else $error("unknown opcode branched");

    // Unsigned order: with the top bits apart, the top bit alone decides.
    // A signed comparator would pick the other operand here.
    AST_MIN_UNS: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_min && st.opa[31] != st.opb[31]
        |=> !rd_data_out[31])
        else $error("min not unsigned");

    AST_MAX_UNS: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go && is_max && st.opa[31] != imm_ext[31]
        |=> rd_data_out[31])
        else $error("max not unsigned");

    // The result stands between execute steps and the done flag follows one.
    AST_RES_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)
        !st.go |=> $stable(st.result))
        else $error("result moved without instruction");

    AST_DONE: assert property (@(posedge clock_in) disable iff (!resetn_in)
        st.go |=> st.done)
        else $error("done flag not set");

    // Bus answer: pready only after a setup, and an error only with pready.
    AST_RDY_ONLY: assert property (@(posedge clock_in) disable iff (!resetn_in)
        pready_out |-> $past(setup))
        else $error("pready without setup");

    AST_ERR_RDY: assert property (@(posedge clock_in) disable iff (!resetn_in)
        pslverr_out |-> pready_out)
        else $error("pslverr without pready");
endmodule : umx_alu
`default_nettype wire

// >>> hdl/umx_pkg.sv
// Package of constants and types for the unsigned max/min execute block.
`default_nettype none
package umx_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_OPA = 8'h04;
    localparam logic [7:0] OFF_OPB = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0c;
    localparam logic [7:0] OFF_RESULT = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    // Instruction field positions.
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int RD_HI = 25;
    localparam int RD_LO = 20;
    localparam int UM_BIT = 19;
    localparam int ABC_HI = 18;
    localparam int ABC_LO = 16;
    localparam int IMM_HI = 9;
    localparam int MOD_HI = 9;
    localparam int MOD_LO = 7;
    localparam int AE_BIT = 6;
    // Major opcodes of the two selection instructions.
    localparam logic [5:0] OPC_MIN_REG = 6'h39;
    localparam logic [5:0] OPC_MAX_IMM = 6'h3c;
    // Compare-select branch condition codes.
    localparam logic [2:0] CC_NEVER = 3'h0;
    localparam logic [2:0] CC_ALWAYS = 3'h1;
    localparam logic [2:0] CC_ZERO = 3'h2;
    localparam logic [2:0] CC_NONZERO = 3'h3;
    localparam logic [2:0] CC_FIRST = 3'h4;
    localparam logic [2:0] CC_SECOND = 3'h5;
    localparam logic [2:0] CC_EQUAL = 3'h6;
    localparam logic [2:0] CC_DIFFER = 3'h7;
    // Status register bit positions.
    localparam int ST_DONE = 0;
    localparam int ST_ILLEGAL = 1;
    localparam int ST_BRANCH = 2;
    localparam int ST_MEM = 3;
    localparam int ST_MOD_LO = 4;
    localparam int ST_AE = 7;
    localparam int ST_RD_LO = 8;
    // Reset values.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic RST_OVF = 1'b0;

    // Everything the execute block holds between clock edges.
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] instr;
        logic [31:0] opa;
        logic [31:0] opb;
        logic ovf;
        logic go;
        logic [31:0] result;
        logic rd_we;
        logic [5:0] rd_idx;
        logic branch;
        logic branch_pulse;
        logic mem_we;
        logic mem_flag;
        logic [2:0] modsel;
        logic ae;
        logic illegal;
        logic done;
    } umx_state_type;
endpackage : umx_pkg
`default_nettype wire

// >>> sim/unsigned_max_min_alu_ops_test.sv
// Self-checking bench for the unsigned max/min execute block.
`default_nettype none
module unsigned_max_min_alu_ops_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [31:0] prdata_out, rd_data_out, mem_data_out;
    logic pready_out, pslverr_out, rd_we_out, branch_out;
    logic mem_we_out, ae_out, ovf_out;
    logic [5:0] rd_idx_out;
    logic [2:0] modsel_out;
    int bad_count = 0;
    int checked = 0;
    // Values seen around the destination write pulse, bus answers, and the stimulus.
    logic seen, err, stay;
    logic [11:0] cap;
    logic [31:0] res, md, rdat, a, b, e, w;
    logic [9:0] imm;
    logic [5:0] rdi;

    umx_alu dut (.clock_in(clock_in), .resetn_in(resetn_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .rd_we_out(rd_we_out), .rd_idx_out(rd_idx_out),
        .rd_data_out(rd_data_out), .branch_out(branch_out),
        .mem_we_out(mem_we_out), .mem_data_out(mem_data_out),
        .modsel_out(modsel_out), .ae_out(ae_out), .ovf_out(ovf_out));

    // Core clock at 40 MHz.
    always #12.5 clock_in = ~clock_in;

    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] y);
        checked++;
        if (y !== x) begin
            $display("ERROR %s expected %h seen %h", nm, x, y);
            bad_count++;
        end
    endtask : chk

    // One APB transfer; a spare edge after release keeps drivers apart.
    task automatic apb(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd);
        int n;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= ad;
        pwdata_in <= wd;
        @(posedge clock_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("ERROR pready expected 1 seen timeout");
            bad_count++;
            give_verdict();
        end
        rdat = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clock_in);
    endtask : apb

    // Loads operands and flags, starts one instruction, catches its pulse.
    task automatic run(input logic [31:0] ins, input logic f);
        apb(1'b1, umx_pkg::OFF_OPA, a);
        apb(1'b1, umx_pkg::OFF_OPB, b);
        apb(1'b1, umx_pkg::OFF_FLAGS, {31'h0, f});
        apb(1'b1, umx_pkg::OFF_INSTR, ins);
        seen = 1'b0;
        for (int k = 0; k < 4 && !seen; k++) begin
            @(posedge clock_in);
            seen = (rd_we_out === 1'b1);
            cap = {branch_out, mem_we_out, modsel_out, ae_out, rd_idx_out};
            res = rd_data_out;
            md = mem_data_out;
        end
        // One more edge: the destination write must have dropped again.
        @(posedge clock_in);
        stay = rd_we_out;
    endtask : run

    function automatic logic exp_br(input logic [2:0] cc,
                                    input logic [31:0] r, x, y);
        case (cc)
            umx_pkg::CC_NEVER: return 1'b0;
            umx_pkg::CC_ALWAYS: return 1'b1;
            umx_pkg::CC_ZERO: return r == 32'h0;
            umx_pkg::CC_NONZERO: return r != 32'h0;
            umx_pkg::CC_FIRST: return r == x;
            umx_pkg::CC_SECOND: return r == y;
            umx_pkg::CC_EQUAL: return x == y;
            default: return x != y;
        endcase
    endfunction : exp_br

    task automatic chk_op(input logic [31:0] y, input logic [2:0] cc,
                          input logic um, input logic [3:0] mae,
                          input logic f);
        chk("issued", 32'h1, 32'(seen));
        chk("result", e, res);
        chk("mem data", e, md);
        chk("pulse end", 32'h0, 32'(stay));
        chk("side", 32'({exp_br(cc, e, a, y), um, mae, rdi}),
            32'(cap));
        chk("ovf", 32'(f), 32'(ovf_out));
    endtask : chk_op

    // Reset, register defaults, an unmapped place, then both opcodes.
    initial begin
        repeat (4) @(posedge clock_in);
        resetn_in <= 1'b1;
        @(posedge clock_in);
        apb(1'b0, umx_pkg::OFF_STATUS, 32'h0);
        chk("status rst", umx_pkg::RST_WORD, rdat);
        apb(1'b0, umx_pkg::OFF_RESULT, 32'h0);
        chk("result rst", umx_pkg::RST_WORD, rdat);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rdat);
        // Unsigned sources with zero, equal and all-ones partners.
        for (int i = 0; i < 32; i++) begin
            a = 32'h8000_0005;
            case (i[4:3])
                2'h0: b = 32'h0000_0007;
                2'h1: b = 32'h0000_0000;
                2'h2: b = a;
                default: b = 32'hffff_ffff;
            endcase
            e = (a < b) ? a : b;
            rdi = 6'h3f - i[5:0];
            run({umx_pkg::OPC_MIN_REG, rdi, i[3], i[2:0], 6'h05,
                 i[2:0] ^ 3'h3, i[4], 6'h0a}, i[0]);
            chk_op(b, i[2:0], i[3], {i[2:0] ^ 3'h3, i[4]}, i[0]);
        end
        // Immediate bits 7:6 always set, 9:8 in three of four groups, so a slack decode would leak them out.
        for (int i = 0; i < 32; i++) begin
            case (i[4:3])
                2'h0: a = 32'h0000_1234;
                2'h1: a = 32'hffff_fff0;
                2'h2: a = 32'hffff_ffc1;
                default: a = 32'h0000_0000;
            endcase
            b = ~a;
            imm = (i[4:3] == 2'h3) ? 10'h0c1 : 10'h3c1;
            w = {{22{imm[9]}}, imm};
            e = (a > w) ? a : w;
            rdi = i[5:0];
            run({umx_pkg::OPC_MAX_IMM, rdi, i[3], i[2:0], 6'h05, imm},
                ~i[0]);
            chk_op(w, i[2:0], i[3], 4'h0, ~i[0]);
        end
        // Result register is read-only and holds the last answer.
        apb(1'b1, umx_pkg::OFF_RESULT, 32'h5a5a_5a5a);
        chk("ro err", 32'h0, 32'(err));
        apb(1'b0, umx_pkg::OFF_RESULT, 32'h0);
        chk("result reg", e, rdat);
        // A neighbouring opcode must not be taken for either instruction.
        run({6'h38, 26'h0000_000}, 1'b0);
        chk("foreign opcode", 32'h0, 32'(seen));
        apb(1'b0, umx_pkg::OFF_STATUS, 32'h0);
        chk("illegal", 32'h1, 32'(rdat[umx_pkg::ST_ILLEGAL]));
        chk("done", 32'h1, 32'(rdat[umx_pkg::ST_DONE]));
        give_verdict();
    end
endmodule : unsigned_max_min_alu_ops_test
`default_nettype wire
